// file: logic/drpi_pkg.sv
// package for the drive run permissive input block
package drpi_pkg;
  // qualification time for a contact change
  localparam int unsigned DEB_TIME_US   = 10;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned DEB_CYCLES    = DEB_TIME_US * CLK_MHZ;
  localparam int unsigned DEB_W         = 9;
  // index of each terminal contact in the pin vector
  localparam int unsigned IDX_RUN       = 0;
  localparam int unsigned IDX_STOP      = 1;
  localparam int unsigned IDX_JOG       = 2;
  localparam int unsigned IDX_DIR       = 3;
  localparam int unsigned IDX_REFSEL    = 4;
  localparam int unsigned IDX_COAST     = 5;
  localparam int unsigned IDX_INTLK     = 6;
  localparam int unsigned IDX_FRESET    = 7;
  localparam int unsigned IDX_BRUSH     = 8;
  localparam int unsigned IDX_THERM     = 9;
  localparam int unsigned NUM_IN        = 10;
  // mask bit positions for the non-required commands
  localparam int unsigned MSK_RUN       = 0;
  localparam int unsigned MSK_JOG       = 1;
  localparam int unsigned MSK_DIR       = 2;
  localparam int unsigned MSK_REFSEL    = 3;
  localparam int unsigned MSK_FRESET    = 4;
  localparam int unsigned NUM_MSK       = 5;
  // status and interrupt bits
  localparam int unsigned EV_COAST      = 0;
  localparam int unsigned EV_INTLK      = 1;
  localparam int unsigned EV_THERM      = 2;
  localparam int unsigned EV_BRUSH      = 3;
  localparam int unsigned NUM_EV        = 4;
  // register offsets
  localparam logic [3:0] REG_MASK       = 4'h0;
  localparam logic [3:0] REG_SOFT       = 4'h1;
  localparam logic [3:0] REG_STAT       = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h3;
  localparam logic [3:0] REG_STATE      = 4'h4;
  localparam logic [3:0] REG_INPUTS     = 4'h5;
  // soft command bits (keypad or network adapter)
  localparam int unsigned SC_RUN        = 0;
  localparam int unsigned SC_STOP       = 1;
  localparam int unsigned SC_JOG        = 2;
  localparam int unsigned SC_DIR        = 3;
  localparam int unsigned SC_REFSEL     = 4;
  localparam int unsigned SC_FRESET     = 5;
  localparam int unsigned NUM_SC        = 6;

  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_JOGGING = 2'b10
  } drpi_state_t;
endpackage

// file: logic/drpi_top.sv
// discrete control input qualification and run permissive logic
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module drpi_top #(
  parameter int unsigned DEB_CYCLES = drpi_pkg::DEB_CYCLES
) (
  input  wire logic                         clk,             // 40 MHz regulator clock
  input  wire logic                         sys_rst,         // synchronous reset
  input  wire logic [drpi_pkg::NUM_IN-1:0]  term_in,         // 24 V contacts, 1 = closed
  input  wire logic [3:0]                   reg_addr,        // register address
  input  wire logic [7:0]                   reg_wdata,       // write data
  input  wire logic                         reg_wr,          // write strobe
  input  wire logic                         reg_rd,          // read strobe
  output logic [7:0]                        reg_rdata,       // read data, cycle after
  output logic                              drive_ready,     // all permissives closed, no latched fault
  output logic                              run_active,      // regulator run
  output logic                              jog_active,      // regulator jog
  output logic                              dir_reverse,     // 1 = reverse
  output logic                              ref1_select,     // 1 = analog ref 1
  output logic                              contactor_close, // ac / braking contactor
  output logic                              fault_latched,   // latched coast fault
  output logic                              brush_warning,   // maintenance warning
  output logic                              irq              // level interrupt
);
  // three-stage synchronisers, compare stages two and three
  logic [drpi_pkg::NUM_IN-1:0] sync1_reg;
  logic [drpi_pkg::NUM_IN-1:0] sync2_reg;
  logic [drpi_pkg::NUM_IN-1:0] sync3_reg;
  logic [drpi_pkg::NUM_IN-1:0] clean_reg;
  logic [drpi_pkg::DEB_W-1:0]  deb_cnt_reg [drpi_pkg::NUM_IN];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= term_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // debounce: a change must persist for the full qualification time
  // a contact still bouncing restarts the count, so it never qualifies
  genvar gi;
  generate
    for (gi = 0; gi < drpi_pkg::NUM_IN; gi++) begin : g_deb
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          deb_cnt_reg[gi] <= '0;
          clean_reg[gi]   <= 1'b0; // open at reset: safe, nothing permitted
        end else if (sync2_reg[gi] != sync3_reg[gi] || sync3_reg[gi] == clean_reg[gi]) begin
          deb_cnt_reg[gi] <= '0;
        end else if (deb_cnt_reg[gi] == drpi_pkg::DEB_W'(DEB_CYCLES - 1)) begin
          deb_cnt_reg[gi] <= '0;
          clean_reg[gi]   <= sync3_reg[gi];
        end else begin
          deb_cnt_reg[gi] <= deb_cnt_reg[gi] + 1'b1;
        end
      end
    end
  endgenerate

  // software registers
  logic [drpi_pkg::NUM_MSK-1:0] mask_reg;     // 1 = terminal input masked off
  logic [drpi_pkg::NUM_SC-1:0]  soft_reg;     // keypad / adapter commands
  logic [drpi_pkg::NUM_EV-1:0]  stat_reg;
  logic [drpi_pkg::NUM_EV-1:0]  irq_mask_reg; // 1 = event enabled
  logic                         wr_mask;
  logic                         wr_soft;
  logic                         wr_stat;
  logic                         wr_imask;
  assign wr_mask  = reg_wr && reg_addr == drpi_pkg::REG_MASK;
  assign wr_soft  = reg_wr && reg_addr == drpi_pkg::REG_SOFT;
  assign wr_stat  = reg_wr && reg_addr == drpi_pkg::REG_STAT;
  assign wr_imask = reg_wr && reg_addr == drpi_pkg::REG_IRQ_MASK;

  // mask and soft-command storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_reg     <= '0;
      soft_reg     <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_mask)  mask_reg     <= reg_wdata[drpi_pkg::NUM_MSK-1:0];
      if (wr_soft)  soft_reg     <= reg_wdata[drpi_pkg::NUM_SC-1:0];
      if (wr_imask) irq_mask_reg <= reg_wdata[drpi_pkg::NUM_EV-1:0];
    end
  end

  // terminal contact unless masked off, or the keypad / adapter command
  function automatic logic merge_cmd(input logic term_bit,
                                     input logic masked_bit,
                                     input logic soft_bit);
    merge_cmd = (term_bit && !masked_bit) || soft_bit;
  endfunction

  // merged command sources
  logic stop_closed, coast_closed, intlk_closed, brush_closed, therm_closed;
  logic cmd_run, cmd_jog, cmd_dir, cmd_ref1, cmd_freset, cmd_stop;
  assign stop_closed  = clean_reg[drpi_pkg::IDX_STOP];
  assign coast_closed = clean_reg[drpi_pkg::IDX_COAST];
  assign intlk_closed = clean_reg[drpi_pkg::IDX_INTLK];
  assign brush_closed = clean_reg[drpi_pkg::IDX_BRUSH];
  assign therm_closed = clean_reg[drpi_pkg::IDX_THERM];
  assign cmd_run    = merge_cmd(clean_reg[drpi_pkg::IDX_RUN], mask_reg[drpi_pkg::MSK_RUN],
                                soft_reg[drpi_pkg::SC_RUN]);
  assign cmd_jog    = merge_cmd(clean_reg[drpi_pkg::IDX_JOG], mask_reg[drpi_pkg::MSK_JOG],
                                soft_reg[drpi_pkg::SC_JOG]);
  assign cmd_dir    = merge_cmd(clean_reg[drpi_pkg::IDX_DIR], mask_reg[drpi_pkg::MSK_DIR],
                                soft_reg[drpi_pkg::SC_DIR]);
  assign cmd_ref1   = merge_cmd(clean_reg[drpi_pkg::IDX_REFSEL], mask_reg[drpi_pkg::MSK_REFSEL],
                                soft_reg[drpi_pkg::SC_REFSEL]);
  assign cmd_freset = merge_cmd(clean_reg[drpi_pkg::IDX_FRESET], mask_reg[drpi_pkg::MSK_FRESET],
                                soft_reg[drpi_pkg::SC_FRESET]);
  // open stop contact or keypad stop
  assign cmd_stop   = !stop_closed || soft_reg[drpi_pkg::SC_STOP];

  logic permit;
  assign permit = stop_closed && coast_closed && intlk_closed && brush_closed && therm_closed;
  // coast trip ignores brush wear, which warns and blocks a start but never stops a run
  logic coast_trip;
  assign coast_trip = !coast_closed || !intlk_closed || !therm_closed;

  // edge detect for run and fault reset, on clean (debounced) signals
  logic run_prev_reg, freset_prev_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_prev_reg    <= 1'b0;
      freset_prev_reg <= 1'b0;
    end else begin
      run_prev_reg    <= cmd_run;
      freset_prev_reg <= cmd_freset;
    end
  end
  logic freset_rise;
  assign freset_rise = cmd_freset && !freset_prev_reg;

  // run state machine
  drpi_pkg::drpi_state_t state_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= drpi_pkg::ST_STOPPED;
    end else begin
      unique case (state_reg)
        drpi_pkg::ST_STOPPED: begin
          if (permit && !fault_latched && !cmd_stop && cmd_run && !run_prev_reg)
            state_reg <= drpi_pkg::ST_RUNNING;
          else if (permit && !fault_latched && !cmd_stop && cmd_jog)
            state_reg <= drpi_pkg::ST_JOGGING;
        end
        drpi_pkg::ST_RUNNING: begin
          if (cmd_stop || coast_trip)
            state_reg <= drpi_pkg::ST_STOPPED;
        end
        drpi_pkg::ST_JOGGING: begin
          if (cmd_stop || coast_trip || !cmd_jog)
            state_reg <= drpi_pkg::ST_STOPPED;
        end
        // unused code falls back to stopped, contactor open
        default: begin
          state_reg <= drpi_pkg::ST_STOPPED;
        end
      endcase
    end
  end

  // outputs from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_ready     <= 1'b0;
      run_active      <= 1'b0;
      jog_active      <= 1'b0;
      dir_reverse     <= 1'b0;
      ref1_select     <= 1'b0;
      contactor_close <= 1'b0;
      brush_warning   <= 1'b0;
    end else begin
      drive_ready     <= permit && !fault_latched;
      run_active      <= state_reg == drpi_pkg::ST_RUNNING && !cmd_stop && !coast_trip;
      jog_active      <= state_reg == drpi_pkg::ST_JOGGING && !cmd_stop && !coast_trip;
      dir_reverse     <= cmd_dir;
      ref1_select     <= cmd_ref1;
      // coast opens the contactor; thermostat too
      contactor_close <= !coast_trip && state_reg != drpi_pkg::ST_STOPPED;
      brush_warning   <= !brush_closed;
    end
  end

  // latched coast fault, cleared by a fault reset edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_latched <= 1'b0;
    end else if (state_reg != drpi_pkg::ST_STOPPED && coast_trip) begin
      fault_latched <= 1'b1; // a new trip wins over a reset
    end else if (freset_rise) begin
      fault_latched <= 1'b0;
    end
  end

  // sticky event status; set wins over write-one-clear
  logic [drpi_pkg::NUM_EV-1:0] ev_now;
  assign ev_now[drpi_pkg::EV_COAST] = !coast_closed;
  assign ev_now[drpi_pkg::EV_INTLK] = !intlk_closed;
  assign ev_now[drpi_pkg::EV_THERM] = !therm_closed;
  assign ev_now[drpi_pkg::EV_BRUSH] = !brush_closed;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= ((freset_rise ? '0 : stat_reg)
                   & ~(wr_stat ? reg_wdata[drpi_pkg::NUM_EV-1:0] : '0)) | ev_now;
    end
  end

  // level interrupt from enabled sticky events
  always_ff @(posedge clk) begin
    if (sys_rst) irq <= 1'b0;
    else         irq <= |(stat_reg & irq_mask_reg);
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        drpi_pkg::REG_MASK:     reg_rdata <= 8'(mask_reg);
        drpi_pkg::REG_SOFT:     reg_rdata <= 8'(soft_reg);
        drpi_pkg::REG_STAT:     reg_rdata <= 8'(stat_reg);
        drpi_pkg::REG_IRQ_MASK: reg_rdata <= 8'(irq_mask_reg);
        drpi_pkg::REG_STATE:    reg_rdata <= {4'h0, fault_latched, permit, state_reg};
        drpi_pkg::REG_INPUTS:   reg_rdata <= clean_reg[7:0];
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_READY: assert property (drive_ready |-> $past(permit))
    else $error("ready without permissives");
  AST_NOMASK: assert property ($past(!stop_closed) |-> !run_active)
    else $error("masked stop still running");
  AST_DIR: assert property (dir_reverse == $past(cmd_dir))
    else $error("direction wrong");
  AST_COAST: assert property (!coast_closed |=> !contactor_close)
    else $error("contactor held on coast");
  AST_INTLK: assert property ((state_reg == drpi_pkg::ST_STOPPED && !intlk_closed)
                              |=> state_reg == drpi_pkg::ST_STOPPED)
    else $error("started without interlock");
  AST_THERM: assert property (!therm_closed |=> !contactor_close)
    else $error("contactor held on thermostat");
  AST_BRUSH: assert property (run_active && !brush_closed && !cmd_stop && !coast_trip
                              |=> state_reg == drpi_pkg::ST_RUNNING)
    else $error("brush wear stopped motor");
  AST_FRST: assert property (freset_rise && !coast_trip |=> !fault_latched)
    else $error("fault not cleared");
  AST_STOP: assert property (cmd_stop |=> ##1 !run_active)
    else $error("stop ignored");
  AST_READY_DROP: assert property (!permit |=> !drive_ready)
    else $error("ready held without permissives");
  // start only on edge or jog
  AST_RUN_EDGE: assert property ((state_reg == drpi_pkg::ST_STOPPED && !cmd_jog
                                  && !(cmd_run && !run_prev_reg))
                                 |=> state_reg == drpi_pkg::ST_STOPPED)
    else $error("started without a run edge");
  AST_JOG_HELD: assert property ((state_reg == drpi_pkg::ST_JOGGING && !cmd_jog)
                                 |=> state_reg == drpi_pkg::ST_STOPPED)
    else $error("jog kept after release");
  AST_INTLK_RUN: assert property ((state_reg == drpi_pkg::ST_RUNNING && !intlk_closed)
                                  |=> state_reg == drpi_pkg::ST_STOPPED && !contactor_close)
    else $error("interlock loss kept running");
  AST_TRIP_LATCH: assert property ((state_reg != drpi_pkg::ST_STOPPED && coast_trip)
                                   |=> fault_latched)
    else $error("trip did not latch fault");
  AST_REF: assert property (ref1_select == $past(cmd_ref1))
    else $error("reference select wrong");
  AST_WARN: assert property (!$past(sys_rst) && !$past(brush_closed)
                             |-> brush_warning)
    else $error("brush warning missing");
  AST_MASK_DIR: assert property (mask_reg[drpi_pkg::MSK_DIR] && !soft_reg[drpi_pkg::SC_DIR]
                                 |=> !dir_reverse)
    else $error("masked direction acted");
  AST_FRST_STAT: assert property (freset_rise && ev_now == '0
                                  |=> stat_reg == '0)
    else $error("alarms not acknowledged");
  AST_STAT_SET: assert property (!coast_closed |=> stat_reg[drpi_pkg::EV_COAST])
    else $error("coast event not recorded");
  // jog output only from jog state
  AST_JOG_OUT: assert property (jog_active
                                |-> $past(state_reg) == drpi_pkg::ST_JOGGING)
    else $error("jog output without jog state");
  AST_CONT_STOP: assert property (state_reg == drpi_pkg::ST_STOPPED
                                  |=> !contactor_close)
    else $error("contactor closed while stopped");
  AST_FAULT_HOLD: assert property (fault_latched && !freset_rise
                                   |=> fault_latched)
    else $error("fault cleared without reset");
  // covers for the main scenarios
  COV_RUN:  cover property (state_reg == drpi_pkg::ST_RUNNING);
  COV_JOG:  cover property (state_reg == drpi_pkg::ST_JOGGING);
  COV_TRIP: cover property (fault_latched ##1 !fault_latched);
  COV_BRUSH_RUN: cover property (run_active && brush_warning);
  COV_SOFT_FRST: cover property (freset_rise && soft_reg[drpi_pkg::SC_FRESET]);
endmodule

// file: sim/drpi_field.sv
// field contact model driving the terminal strip
`timescale 1ns/1ps
module drpi_field (
  input  wire logic                   clk,    // regulator clock
  output logic [drpi_pkg::NUM_IN-1:0] term_in // contacts, 1 = closed
);
  // unwired strip reads all open at power-up
  initial term_in = '0;
  // move one contact just after an edge
  task automatic set_pin(input int idx, input logic val);
    @(posedge clk);
    term_in[idx] <= val;
  endtask
  // contact bounce, shorter than qualification time
  task automatic glitch(input int idx, input int len);
    @(posedge clk);
    term_in[idx] <= ~term_in[idx];
    repeat (len) @(posedge clk);
    term_in[idx] <= ~term_in[idx];
  endtask
endmodule

// file: sim/drpi_top_tb.sv
// self-checking bench for the run permissive input block
`timescale 1ns/1ps
module drpi_top_tb;
  localparam int RUN = drpi_pkg::IDX_RUN;
  localparam int STP = drpi_pkg::IDX_STOP;
  localparam int JOG = drpi_pkg::IDX_JOG;
  localparam int DIR = drpi_pkg::IDX_DIR;
  localparam int REF = drpi_pkg::IDX_REFSEL;
  localparam int FRS = drpi_pkg::IDX_FRESET;
  logic       clk;
  logic       sys_rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [9:0] term_in;
  logic       drive_ready;
  logic       run_active;
  logic       jog_active;
  logic       dir_reverse;
  logic       ref1_select;
  logic       contactor_close;
  logic       fault_latched;
  logic       brush_warning;
  logic       irq;
  int         n_mismatch;
  int         checks;
  // the five permissives, and the three trips that drop the contactor
  int perm[5] = '{STP, drpi_pkg::IDX_COAST, drpi_pkg::IDX_INTLK, 8, 9};
  int trip[3] = '{drpi_pkg::IDX_INTLK, 9, drpi_pkg::IDX_COAST};

  // short count keeps the run brief; the fixed 20-cycle settle below covers it
  drpi_top #(.DEB_CYCLES(4)) DUT (.clk(clk), .sys_rst(sys_rst), .term_in(term_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive_ready(drive_ready), .run_active(run_active),
    .jog_active(jog_active), .dir_reverse(dir_reverse), .ref1_select(ref1_select),
    .contactor_close(contactor_close), .fault_latched(fault_latched),
    .brush_warning(brush_warning), .irq(irq));
  drpi_field field (.clk(clk), .term_in(term_in));

  // 40 MHz regulator clock
  always #12.5 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask
  // sync plus qualification plus output registers, with margin
  task automatic settle();
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic pin(input int idx, input logic v);
    field.set_pin(idx, v);
    settle();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog, far beyond the roughly 1200 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    chk(drive_ready, 0, "ready out of reset");
    foreach (perm[i]) field.set_pin(perm[i], 1'b1);
    settle();
    chk(drive_ready, 1, "ready all closed");
    rd(drpi_pkg::REG_INPUTS, 8'h62, "debounced inputs");
    rd(4'hf, 8'h00, "unmapped read");
    // power-up leaves every event set; clear, then enable all on the interrupt
    wr(drpi_pkg::REG_STAT, 8'h0f);
    wr(drpi_pkg::REG_IRQ_MASK, 8'h0f);
    rd(drpi_pkg::REG_STAT, 8'h00, "status cleared");
    chk(irq, 0, "irq idle");
    // masking every command must leave the permissives in force
    wr(drpi_pkg::REG_MASK, 8'h1f);
    foreach (perm[i]) begin
      pin(perm[i], 1'b0);
      chk(drive_ready, 0, "ready one open");
      chk(brush_warning, i == 3, "warning only on brush");
      pin(perm[i], 1'b1);
    end
    rd(drpi_pkg::REG_STAT, 8'h0f, "sticky status");
    chk(irq, 1, "irq raised");
    wr(drpi_pkg::REG_STAT, 8'h0f);
    wr(drpi_pkg::REG_MASK, 8'h00);
    settle();
    chk(irq, 0, "irq cleared");
    pin(RUN, 1'b1);
    chk(contactor_close, 1, "run closes contactor");
    rd(drpi_pkg::REG_STATE, 8'h05, "state running");
    pin(DIR, 1'b1);
    chk(dir_reverse, 1, "dir closed reverse");
    pin(DIR, 1'b0);
    chk(dir_reverse, 0, "dir open forward");
    pin(REF, 1'b1);
    chk(ref1_select, 1, "ref select closed");
    pin(REF, 1'b0);
    chk(ref1_select, 0, "ref select open");
    // brush warning event left off the interrupt enables
    wr(drpi_pkg::REG_IRQ_MASK, 8'h07);
    pin(8, 1'b0);
    chk(run_active, 1, "still runs on brush");
    chk(irq, 0, "masked irq");
    pin(8, 1'b1);
    wr(drpi_pkg::REG_IRQ_MASK, 8'h0f);
    settle();
    chk(irq, 1, "unmasked irq");
    wr(drpi_pkg::REG_STAT, 8'h08);
    settle();
    chk(irq, 0, "irq after clear");
    foreach (trip[i]) begin
      pin(trip[i], 1'b0);
      chk(contactor_close, 0, "trip drops contactor");
      chk(fault_latched, 1, "trip latches fault");
      pin(trip[i], 1'b1);
      chk(run_active, 0, "no restart after trip");
      if (i == 1) begin
        wr(drpi_pkg::REG_SOFT, 8'h01 << drpi_pkg::SC_FRESET);
        wr(drpi_pkg::REG_SOFT, 8'h00);
        settle();
      end else begin
        pin(FRS, 1'b1);
        pin(FRS, 1'b0);
      end
      chk(fault_latched, 0, "fault reset clears");
      pin(RUN, 1'b0);
      pin(RUN, 1'b1);
      chk(run_active, 1, "restart after reset");
    end
    wr(drpi_pkg::REG_STAT, 8'h0f);
    pin(STP, 1'b0);
    chk(run_active, 0, "stop open stops");
    pin(STP, 1'b1);
    chk(run_active, 0, "stop closed no restart");
    pin(RUN, 1'b0);
    pin(drpi_pkg::IDX_INTLK, 1'b0);
    pin(RUN, 1'b1);
    chk(run_active, 0, "interlock blocks start");
    pin(RUN, 1'b0);
    pin(drpi_pkg::IDX_INTLK, 1'b1);
    field.glitch(RUN, 2);
    settle();
    chk(run_active, 0, "bounce refused");
    pin(JOG, 1'b1);
    chk(jog_active, 1, "jog while held");
    chk(contactor_close, 1, "jog contactor");
    pin(JOG, 1'b0);
    chk(jog_active, 0, "jog released");
    // direction and run handed to the keypad side
    wr(drpi_pkg::REG_MASK, 8'h01 << drpi_pkg::MSK_DIR);
    pin(DIR, 1'b1);
    chk(dir_reverse, 0, "masked terminal dir");
    wr(drpi_pkg::REG_SOFT, 8'h01 << drpi_pkg::SC_DIR);
    settle();
    chk(dir_reverse, 1, "soft dir");
    wr(drpi_pkg::REG_SOFT, 8'h00);
    wr(drpi_pkg::REG_MASK, 8'h01 << drpi_pkg::MSK_RUN);
    pin(DIR, 1'b0);
    pin(RUN, 1'b1);
    chk(run_active, 0, "masked terminal run");
    // keypad side starts and stops the drive on its own
    wr(drpi_pkg::REG_SOFT, 8'h01 << drpi_pkg::SC_RUN);
    settle();
    chk(run_active, 1, "soft run starts");
    wr(drpi_pkg::REG_SOFT, (8'h01 << drpi_pkg::SC_RUN) | (8'h01 << drpi_pkg::SC_STOP));
    settle();
    chk(run_active, 0, "soft stop stops");
    wr(drpi_pkg::REG_SOFT, 8'h00);
    rd(drpi_pkg::REG_MASK, 8'h01, "mask readback");
    complete_run();
  end
endmodule
